// ---- issp_slave.sv ----
// i2c slave serial port: pin sampling on the link clock, protocol engine and flags on clk
// Function
// - four-bit mode field picks 7-bit, 10-bit, either with start/stop irq, or master.
// - enabled i2c mode drives clock and data pins open drain when directions are input.
// - 7-bit and 10-bit addressing; no general call response.
// - after enable wait for start, then shift eight bits on rising clock edges.
// - compare shift bits 7..1 with own address at the eighth falling edge.
// - match with flags clear copies byte, sets full, acks, irq at ninth fall.
// - full or overflow already set: no copy, no ack, irq still set.
// - buffer read clears full; overflow and irq cleared only by software.
// - 10-bit first byte is 11110, address bits 9 and 8, write bit.
// - each 10-bit address byte of a write sets irq, full, update flag and holds clock low.
// - repeated start plus resent high byte for read sets irq, full and read/write, not update.
// - matched write address clears read/write bit and buffers the address.
// - every transferred data byte raises the irq flag.
// - matched read address sets read/write, buffers address, acks, then holds clock.
// - transmit write loads shift register; clock held until release bit set.
// - transmit bits change on falling clock edges.
// - transmitting, irq set at the ninth falling edge of each byte.
// - master ack latched on ninth rise; nack resets slave and status.
// - start/stop irq modes raise irq on each start and stop.
// - slave transmitter pulls data low for zero bits.
// - mode 1011 is master with slave idle, start/stop irq active.
// - start and stop seen bits cleared by reset or disable, follow last condition.
`include "issp_regs.svh"
`default_nettype none
module issp_slave #(
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic link_clk,
    input wire logic port_enable_bit,
    input wire logic [3:0] port_mode_field,
    input wire logic scl_dir_in,
    input wire logic sda_dir_in,
    input wire issp_pkg::issp_fw_cmd_t fw_cmd,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe,
    output logic sda_o,
    output logic sda_oe,
    output logic [7:0] transfer_buffer_reg,
    output logic [7:0] own_address_reg,
    output var issp_pkg::issp_status_t port_status
);
    import issp_pkg::*;

    if (DW != 8) begin : g_bad_width
        $error("issp_slave serves 8-bit bytes only");
    end

    // ---------------- link domain: pin sampling and bus events ----------------
    logic [1:0] lrst_sync;
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic l_tog;
    issp_evt_t l_evt;
    wire logic link_rst = lrst_sync[1];
    wire logic l_rise = scl_sync[1] & ~scl_sync[2];
    wire logic l_fall = ~scl_sync[1] & scl_sync[2];
    wire logic l_sclh = scl_sync[1] & scl_sync[2];
    wire logic l_start = l_sclh & sda_sync[2] & ~sda_sync[1];
    wire logic l_stop = l_sclh & ~sda_sync[2] & sda_sync[1];
    wire logic l_any = l_rise | l_fall | l_start | l_stop;
    issp_evt_kind_t l_kind;
    assign l_kind = l_rise ? EV_RISE : l_fall ? EV_FALL : l_start ? EV_START : EV_STOP;

    always_ff @(posedge link_clk) begin
        lrst_sync <= {lrst_sync[0], srst};
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_i};
            sda_sync <= {sda_sync[1:0], sda_i};
        end
    end

    // event word is held until the next bus event, far longer than the toggle crossing
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            l_tog <= 1'b0;
            l_evt <= '0;
        end else if (l_any) begin
            l_tog <= ~l_tog;
            l_evt <= '{kind: l_kind, sda: sda_sync[1]};
        end
    end

    // ---------------- core domain ----------------
    logic [2:0] tog_sync;
    always_ff @(posedge clk) begin
        if (srst) begin
            tog_sync <= 3'h0;
        end else begin
            tog_sync <= {tog_sync[1:0], l_tog};
        end
    end
    wire logic ev_v = tog_sync[1] ^ tog_sync[2];
    wire logic rise = ev_v && l_evt.kind == EV_RISE;
    wire logic fall = ev_v && l_evt.kind == EV_FALL;
    wire logic start_ev = ev_v && l_evt.kind == EV_START;
    wire logic stop_ev = ev_v && l_evt.kind == EV_STOP;

    issp_state_t state;
    issp_state_t next_state;
    logic [3:0] cnt;
    logic [7:0] sr;
    logic sda_low;
    logic byte_pend;
    logic ua_pend;
    logic ten_ok;
    logic mack;

    // mode decode
    wire logic [3:0] m = port_mode_field;
    wire logic ten = m == `ISSP_MODE_SLV10 || m == `ISSP_MODE_SLV10_SS;
    wire logic slave_on = port_enable_bit && (m == `ISSP_MODE_SLV7 || m == `ISSP_MODE_SLV10 ||
                                              m == `ISSP_MODE_SLV7_SS || m == `ISSP_MODE_SLV10_SS);
    wire logic ss_irq = m == `ISSP_MODE_SLV7_SS || m == `ISSP_MODE_SLV10_SS || m == `ISSP_MODE_MASTER;
    wire logic i2c_on = slave_on || (port_enable_bit && m == `ISSP_MODE_MASTER);
    wire logic scl_pins_ok = i2c_on && scl_dir_in;
    wire logic sda_pins_ok = i2c_on && sda_dir_in;

    // byte slots
    wire logic ack_slot = fall && cnt == `ISSP_ACK_CNT;
    wire logic end_slot = fall && cnt == `ISSP_END_CNT;
    wire logic tx_shift = fall && state == ST_TX && cnt != 4'h0 && cnt < `ISSP_ACK_CNT;
    wire logic rx_state = state == ST_ADDR || state == ST_ADDR2 || state == ST_RX || state == ST_SKIP;
    wire logic hi_match = sr[7:3] == `ISSP_TEN_HDR && sr[2:1] == own_address_reg[2:1];
    wire logic match7 = sr[7:1] == own_address_reg[7:1];
    wire logic is_read = sr[0];
    wire logic addr_hit = state == ST_ADDR ? (ten ? hi_match && (!is_read || ten_ok) : match7)
                        : (state == ST_ADDR2 && sr == own_address_reg);
    wire logic rx_byte = state == ST_RX || addr_hit;
    wire logic clean = !port_status.buffer_full_flag && !port_status.receive_overflow_flag;
    wire logic take = ack_slot && rx_byte && clean;
    wire logic refuse = ack_slot && rx_byte && !clean;
    wire logic tx_end = end_slot && state == ST_TX;
    wire logic nack_rst = tx_end && !mack;
    wire logic off = srst || !port_enable_bit;
    wire logic hold = port_status.address_update_flag || (state == ST_TX && !port_status.clock_release_bit);

    always_comb begin
        next_state = state;
        if (!slave_on) begin
            next_state = ST_IDLE;
        end else if (start_ev) begin
            next_state = ST_ADDR;
        end else if (stop_ev) begin
            next_state = ST_IDLE;
        end else if (ack_slot) begin
            case (state)
                ST_ADDR: begin
                    if (!addr_hit || !clean) begin
                        next_state = ST_SKIP;
                    end else if (is_read) begin
                        next_state = ST_TXA;
                    end else if (ten && !ten_ok) begin
                        next_state = ST_ADDR2;
                    end else begin
                        next_state = ST_RX;
                    end
                end
                ST_ADDR2: next_state = addr_hit && clean ? ST_RX : ST_SKIP;
                default: next_state = state;
            endcase
        end else if (end_slot && state == ST_TXA) begin
            next_state = ST_TX;
        end else if (nack_rst) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (off) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // bit counter: counts rising clock edges within the byte
    always_ff @(posedge clk) begin
        if (off || start_ev || end_slot) begin
            cnt <= 4'h0;
        end else if (rise && cnt < `ISSP_END_CNT) begin
            cnt <= cnt + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (off) begin
            sr <= `ISSP_BYTE_RST;
        end else if (rise && rx_state && cnt < `ISSP_ACK_CNT) begin
            sr <= {sr[6:0], l_evt.sda};
        end else if (fw_cmd.buf_wr && state == ST_TX) begin
            sr <= fw_cmd.wdata;
        end else if (tx_shift) begin
            sr <= {sr[6:0], 1'b0};
        end
    end

    // pull data low: ack slot on receive, zero bits on transmit, released for master ack
    always_ff @(posedge clk) begin
        if (off || end_slot || start_ev || stop_ev) begin
            sda_low <= 1'b0;
        end else if (ack_slot) begin
            sda_low <= take && state != ST_TX;
        end else if (fw_cmd.buf_wr && state == ST_TX && cnt == 4'h0) begin
            sda_low <= ~fw_cmd.wdata[7];
        end else if (tx_shift) begin
            sda_low <= ~sr[6];
        end
    end

    always_ff @(posedge clk) begin
        if (off || start_ev || stop_ev) begin
            byte_pend <= 1'b0;
            ua_pend <= 1'b0;
        end else if (ack_slot) begin
            byte_pend <= rx_byte || state == ST_TX;
            ua_pend <= ten && rx_byte && (state == ST_ADDR2 || (state == ST_ADDR && !is_read));
        end
    end

    always_ff @(posedge clk) begin
        if (off || stop_ev) begin
            ten_ok <= 1'b0;
        end else if (ack_slot && state == ST_ADDR2 && take) begin
            ten_ok <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (off) begin
            mack <= 1'b0;
        end else if (rise && state == ST_TX && cnt == `ISSP_ACK_CNT) begin
            mack <= ~l_evt.sda;
        end
    end

    // firmware-visible flags: every hardware set beats the clear of the same cycle
    always_ff @(posedge clk) begin
        if (off) begin
            port_status <= '0;
        end else begin
            port_status.buffer_full_flag <= take || (port_status.buffer_full_flag && !fw_cmd.buf_rd
                                                     && !nack_rst);
            port_status.receive_overflow_flag <= (refuse && port_status.buffer_full_flag)
                                               || (port_status.receive_overflow_flag && !fw_cmd.ov_clr);
            port_status.port_irq_flag <= (end_slot && byte_pend) || ((start_ev || stop_ev) && ss_irq)
                                       || (port_status.port_irq_flag && !fw_cmd.irq_clr);
            port_status.address_update_flag <= (end_slot && ua_pend)
                                             || (port_status.address_update_flag && !fw_cmd.addr_wr
                                                 && !nack_rst);
            if (ack_slot && state == ST_ADDR && addr_hit) begin
                port_status.read_write <= is_read;
            end else if (nack_rst) begin
                port_status.read_write <= 1'b0;
            end
            if (ack_slot && rx_byte) begin
                port_status.data_not_address <= state == ST_RX;
            end else if (nack_rst) begin
                port_status.data_not_address <= 1'b0;
            end
            if (fw_cmd.release_set) begin
                port_status.clock_release_bit <= 1'b1;
            end else if ((end_slot && state == ST_TXA) || (tx_end && mack)) begin
                port_status.clock_release_bit <= 1'b0;
            end
            if (start_ev) begin
                port_status.start_seen <= 1'b1;
                port_status.stop_seen <= 1'b0;
            end else if (stop_ev) begin
                port_status.start_seen <= 1'b0;
                port_status.stop_seen <= 1'b1;
            end
        end
    end

    // buffer and own address keep their contents across a disable
    always_ff @(posedge clk) begin
        if (srst) begin
            transfer_buffer_reg <= `ISSP_BYTE_RST;
        end else if (take) begin
            transfer_buffer_reg <= sr;
        end else if (fw_cmd.buf_wr) begin
            transfer_buffer_reg <= fw_cmd.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            own_address_reg <= `ISSP_ADDR_RST;
        end else if (fw_cmd.addr_wr) begin
            own_address_reg <= fw_cmd.wdata;
        end
    end

    // open drain: the output level is always low, only the enables move
    always_ff @(posedge clk) begin
        if (off) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            scl_oe <= scl_pins_ok && hold;
            sda_oe <= sda_pins_ok && sda_low;
        end
        scl_o <= 1'b0;
        sda_o <= 1'b0;
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_refuse_no_ack: assert property (refuse |=> ##1 !sda_oe)
        else $error("refused byte was acknowledged");
    chk_take_loads: assert property (take |=> transfer_buffer_reg == $past(sr) && port_status.buffer_full_flag)
        else $error("accepted byte not buffered");
    chk_irq_ninth: assert property (end_slot && byte_pend && port_enable_bit |=> port_status.port_irq_flag)
        else $error("no irq at ninth falling edge");
    chk_bf_read_clear: assert property (fw_cmd.buf_rd && !take && !off |=> !port_status.buffer_full_flag)
        else $error("buffer read did not clear full flag");
    chk_ov_sticky: assert property (port_status.receive_overflow_flag && !fw_cmd.ov_clr && !off
                                    |=> port_status.receive_overflow_flag)
        else $error("overflow flag cleared without software");
    chk_ua_stretch: assert property (end_slot && ua_pend && port_enable_bit && scl_pins_ok && !fw_cmd.addr_wr
                                     ##1 scl_pins_ok |=> scl_oe)
        else $error("clock not held after 10-bit address byte");
    chk_disable_idle: assert property (!port_enable_bit |=> state == ST_IDLE ##1 (!sda_oe && !scl_oe))
        else $error("disable did not release bus");
    chk_start_flag: assert property (start_ev && port_enable_bit |=> port_status.start_seen
                                     && !port_status.stop_seen)
        else $error("start seen not tracking bus");
    chk_ss_irq: assert property ((start_ev || stop_ev) && ss_irq && port_enable_bit
                                 |=> port_status.port_irq_flag)
        else $error("start or stop irq missing");
    chk_nack_reset: assert property (nack_rst && port_enable_bit |=> state == ST_IDLE
                                     && !port_status.read_write)
        else $error("nack did not reset slave");
    chk_od_gate: assert property (sda_oe |-> $past(sda_pins_ok))
        else $error("data pin driven outside enabled input mode");
    chk_sample_rise: assert property (rise && rx_state && cnt < `ISSP_ACK_CNT && !off
                                      |=> sr[0] == $past(l_evt.sda))
        else $error("bit not sampled on rising edge");

    cov_rx_take: cover property (take && state == ST_RX);
    cov_tx_entry: cover property (end_slot && state == ST_TXA);
    cov_ten_ua: cover property (end_slot && ua_pend);
    cov_tx_nack: cover property (nack_rst);
endmodule
`default_nettype wire

// ---- issp_regs.svh ----
// constants for the i2c slave serial port: mode codes, field values, reset values, bit counts
`ifndef ISSP_REGS_SVH
`define ISSP_REGS_SVH
`define ISSP_MODE_SLV7 4'h6
`define ISSP_MODE_SLV10 4'h7
`define ISSP_MODE_MASTER 4'hb
`define ISSP_MODE_SLV7_SS 4'he
`define ISSP_MODE_SLV10_SS 4'hf
`define ISSP_TEN_HDR 5'h1e
`define ISSP_ACK_CNT 4'h8
`define ISSP_END_CNT 4'h9
`define ISSP_BYTE_RST 8'h00
`define ISSP_ADDR_RST 8'h00
`endif

// ---- issp_pkg.sv ----
// types shared by the i2c slave serial port
`default_nettype none
package issp_pkg;
    typedef enum logic [1:0] {EV_RISE, EV_FALL, EV_START, EV_STOP} issp_evt_kind_t;
    typedef struct packed {
        issp_evt_kind_t kind;
        logic sda;
    } issp_evt_t;
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR2, ST_RX, ST_TXA, ST_TX, ST_SKIP} issp_state_t;
    typedef struct packed {
        logic buf_wr;
        logic buf_rd;
        logic addr_wr;
        logic release_set;
        logic ov_clr;
        logic irq_clr;
        logic [7:0] wdata;
    } issp_fw_cmd_t;
    typedef struct packed {
        logic receive_overflow_flag;
        logic clock_release_bit;
        logic data_not_address;
        logic stop_seen;
        logic start_seen;
        logic read_write;
        logic address_update_flag;
        logic buffer_full_flag;
        logic port_irq_flag;
    } issp_status_t;
endpackage
`default_nettype wire

// ---- issp_i2c_master_model.sv ----
// behavioural i2c bus master driving the slave's clock and data lines open drain
`default_nettype none
module issp_i2c_master_model #(
    parameter int QTR_NS = 300
) (
    input wire logic scl,
    input wire logic sda,
    output var logic scl_oe,
    output var logic sda_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    int stuck;
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
        stuck = 0;
    end
    // slow slave may stretch: wait up to 20000 steps of 10 ns for the line to go high, then go on and count it in stuck
    task automatic wait_high();
        int n;
        n = 0;
        while (scl !== 1'b1 && n < 20000) begin
            #10;
            n++;
        end
        if (scl !== 1'b1) stuck++;
    endtask
    // data set while clock is low, sampled mid-high, held a quarter after the fall
    task automatic pulse(input logic bit_out, output logic bit_in);
        sda_oe = ~bit_out;
        #QTR_NS;
        scl_oe = 1'b0;
        wait_high();
        #QTR_NS;
        bit_in = sda;
        #QTR_NS;
        scl_oe = 1'b1;
        #QTR_NS;
    endtask
    // also serves as repeated start when entered with clock low
    task automatic start();
        sda_oe = 1'b0;
        #QTR_NS;
        scl_oe = 1'b0;
        wait_high();
        #QTR_NS;
        sda_oe = 1'b1;
        #QTR_NS;
        scl_oe = 1'b1;
        #QTR_NS;
    endtask
    task automatic stop();
        sda_oe = 1'b1;
        #QTR_NS;
        scl_oe = 1'b0;
        wait_high();
        #QTR_NS;
        sda_oe = 1'b0;
        #QTR_NS;
    endtask
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) pulse(d[i], b);
        pulse(1'b1, b);
        ack = ~b;
    endtask
    task automatic read_byte(input logic ack_out, output logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
        pulse(~ack_out, b);
    endtask
endmodule
`default_nettype wire

// ---- issp_slave_tb_top.sv ----
// self-checking bench for the i2c slave serial port against a bus master model
`include "issp_regs.svh"
`default_nettype none
module issp_slave_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import issp_pkg::*;
    localparam logic [5:0] F_WR = 6'h20, F_RD = 6'h10, F_AD = 6'h08, F_REL = 6'h04, F_OV = 6'h02, F_IRQ = 6'h01;
    logic clk = 1'b0, link_clk = 1'b0, srst = 1'b1, en = 1'b0, scl_dir = 1'b1, sda_dir = 1'b1;
    logic [3:0] mode = `ISSP_MODE_SLV7;
    issp_fw_cmd_t fw_cmd = '0;
    issp_status_t st;
    logic scl_o, scl_oe, sda_o, sda_oe, m_scl_oe, m_sda_oe, ack, prev_irq;
    logic [7:0] buf_q, own_q, tx, rx;
    logic [14:0] exp_q[$], msk_q[$], e, k;
    int miscompares = 0, comparisons = 0;
    // pull-ups on both lines
    wire scl_w = (scl_oe | m_scl_oe) ? 1'b0 : 1'b1;
    wire sda_w = (sda_oe | m_sda_oe) ? 1'b0 : 1'b1;
    always #5 clk = ~clk;
    initial begin
        #3;
        forever #7.5 link_clk = ~link_clk;
    end
    issp_slave uut (.clk(clk), .srst(srst), .link_clk(link_clk), .port_enable_bit(en), .port_mode_field(mode),
        .scl_dir_in(scl_dir), .sda_dir_in(sda_dir), .fw_cmd(fw_cmd), .scl_i(scl_w), .sda_i(sda_w),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .transfer_buffer_reg(buf_q),
        .own_address_reg(own_q), .port_status(st));
    issp_i2c_master_model m (.scl(scl_w), .sda(sda_w), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
    task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // layout: buffer, overflow, data/address, read/write, update, full, start seen, stop seen
    task automatic note(input logic [14:0] v, input logic [14:0] msk);
        exp_q.push_back(v);
        msk_q.push_back(msk);
    endtask
    task automatic fw(input logic [5:0] p, input logic [7:0] d);
        @(posedge clk) fw_cmd <= {p, d};
        @(posedge clk) fw_cmd <= '0;
        @(posedge clk);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // every rise of the irq flag consumes the oldest expectation; an unexpected one fails
    always @(posedge clk) begin
        prev_irq <= st.port_irq_flag;
        if (!srst && st.port_irq_flag === 1'b1 && prev_irq === 1'b0) begin
            if (exp_q.size() == 0) begin
                chk(15'h0000, 15'h7fff);
            end else begin
                e = exp_q.pop_front();
                k = msk_q.pop_front();
                chk({buf_q, st.receive_overflow_flag, st.data_not_address, st.read_write, st.address_update_flag,
                    st.buffer_full_flag, st.start_seen, st.stop_seen} & k, e & k);
            end
        end
    end
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h4d0a0723));
        // longer than three cycles so the link-side synchroniser also sees reset
        idle(6);
        srst <= 1'b0;
        @(posedge clk);
        chk({st, scl_oe, sda_oe}, 15'h0000);
        chk({buf_q, own_q}, 15'h0000);
        en <= 1'b1;
        idle(4);
        fw(F_AD, 8'h84);
        chk(own_q, 15'h0084);
        // 7-bit write, overflow and flag clearing
        note({8'h84, 7'b0000100}, 15'h7ff4);
        m.start();
        m.write_byte(8'h84, ack);
        chk(ack, 1);
        fw(F_IRQ, 8'h00);
        note({8'h84, 7'b1000100}, 15'h7fc4);
        m.write_byte(8'h3c, ack);
        chk(ack, 0);
        fw(F_RD | F_IRQ, 8'h00);
        chk({st.receive_overflow_flag, st.buffer_full_flag, st.port_irq_flag}, 3'b100);
        note({8'h84, 7'b1000000}, 15'h7fc4);
        m.write_byte(8'ha5, ack);
        chk(ack, 0);
        fw(F_OV | F_IRQ, 8'h00);
        chk(st.receive_overflow_flag, 0);
        note({8'ha5, 7'b0100100}, 15'h7ff4);
        m.write_byte(8'ha5, ack);
        chk(ack, 1);
        fw(F_RD | F_IRQ, 8'h00);
        m.stop();
        // foreign address and general call are ignored
        for (int i = 0; i < 2; i++) begin
            m.start();
            m.write_byte(i == 0 ? 8'h86 : 8'h00, ack);
            chk(ack, 0);
            m.stop();
        end
        // 7-bit read with stretching
        note({8'h85, 7'b0010100}, 15'h7ff4);
        m.start();
        m.write_byte(8'h85, ack);
        chk(ack, 1);
        fw(F_RD | F_IRQ, 8'h00);
        chk({scl_oe, st.clock_release_bit}, 2'b10);
        scl_dir <= 1'b0;
        idle(4);
        chk(scl_oe, 0);
        scl_dir <= 1'b1;
        idle(4);
        // bit 7 kept low so the data pin is pulled while the clock is held
        tx = {1'b0, 7'($urandom())};
        fw(F_WR, tx);
        idle(1);
        chk(sda_oe, 1);
        sda_dir <= 1'b0;
        idle(4);
        chk(sda_oe, 0);
        sda_dir <= 1'b1;
        idle(4);
        note({tx, 7'b0010000}, 15'h7f90);
        fork
            m.read_byte(1'b1, rx);
            begin
                idle(150);
                chk(scl_oe, 1);
                fw(F_REL, 8'h00);
            end
        join
        chk(rx, tx);
        fw(F_IRQ, 8'h00);
        chk(scl_oe, 1);
        tx = 8'($urandom());
        fw(F_WR, tx);
        fw(F_REL, 8'h00);
        note({tx, 7'b0}, 15'h7f80);
        m.read_byte(1'b0, rx);
        chk(rx, tx);
        chk({st.read_write, scl_oe, sda_oe}, 3'b000);
        fw(F_IRQ, 8'h00);
        m.stop();
        // 10-bit write then repeated start for read
        @(posedge clk) mode <= `ISSP_MODE_SLV10;
        fw(F_AD, 8'hf6);
        note({8'hf6, 7'b0001100}, 15'h7ffc);
        m.start();
        m.write_byte(8'hf6, ack);
        chk({ack, scl_oe}, 2'b11);
        fw(F_RD | F_IRQ, 8'h00);
        fw(F_AD, 8'h3b);
        idle(1);
        chk({st.address_update_flag, scl_oe}, 2'b00);
        note({8'h3b, 7'b0001100}, 15'h7ffc);
        m.write_byte(8'h3b, ack);
        chk({ack, scl_oe}, 2'b11);
        fw(F_RD | F_IRQ, 8'h00);
        fw(F_AD, 8'hf6);
        note({8'h77, 7'b0100100}, 15'h7ff4);
        m.write_byte(8'h77, ack);
        chk(ack, 1);
        fw(F_RD | F_IRQ, 8'h00);
        note({8'hf7, 7'b0010100}, 15'h7f9c);
        m.start();
        m.write_byte(8'hf7, ack);
        chk({ack, scl_oe}, 2'b11);
        @(posedge clk) en <= 1'b0;
        idle(4);
        chk({st, scl_oe, sda_oe}, 15'h0000);
        en <= 1'b1;
        m.stop();
        // start/stop interrupts in every mode that has them
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) mode <= (i == 0) ? `ISSP_MODE_SLV7_SS : (i == 1) ? `ISSP_MODE_SLV10_SS : `ISSP_MODE_MASTER;
            idle(4);
            note(15'h0002, 15'h0003);
            m.start();
            fw(F_IRQ, 8'h00);
            if (i == 2) begin
                m.write_byte(8'hf6, ack);
                chk(ack, 0);
            end
            note(15'h0001, 15'h0003);
            m.stop();
            idle(20);
            fw(F_IRQ, 8'h00);
        end
        chk(15'(exp_q.size()), 15'h0000);
        chk(15'(m.stuck), 15'h0000);
        wrap_up();
    end
endmodule
`default_nettype wire
